// file: design/oag_disp_add.sv
`timescale 1ns/10ps
`default_nettype none
module oag_disp_add (
   input wire logic [15:0] base_i,  // Base address
   input wire logic [7:0] disp_i,   // Two's complement displacement
   output logic [15:0] sum_o        // Base plus sign-extended displacement
);
   // Wraps modulo 64K, so the reach is -128..+127 around the base
   assign sum_o = base_i + oag_pkg::sext8(disp_i);
endmodule
`default_nettype wire

// file: design/oag_pkg.sv
package oag_pkg;
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [15:0] STEP_ONE = 16'h0001;
   localparam logic [15:0] STEP_TWO = 16'h0002;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // Opcode field positions
   localparam int OPC_HI_MSB = 5;
   localparam int OPC_HI_LSB = 3;
   localparam int OPC_LO_MSB = 2;
   localparam int OPC_LO_LSB = 0;
   // Restart target layout
   localparam logic [9:0] RST_UPPER = 10'h000;
   localparam logic [2:0] RST_LOWER = 3'h0;
   // Register code of the accumulator
   localparam logic [2:0] ACC_CODE = 3'h7;
   localparam logic [2:0] ZERO_SEL = 3'h0;

   typedef enum logic [3:0] {
      OAG_IMM8,
      OAG_IMM16,
      OAG_EXT,
      OAG_RST,
      OAG_REL,
      OAG_IDX,
      OAG_REG,
      OAG_IMPL,
      OAG_REGIND,
      OAG_BIT,
      OAG_PUSH,
      OAG_POP
   } oag_mode_t;

   typedef enum logic [1:0] {
      OAG_TGT_REG,
      OAG_TGT_IND,
      OAG_TGT_IDX
   } oag_bit_tgt_t;

   function automatic logic [15:0] sext8(input logic [7:0] b);
      sext8 = {{8{b[7]}}, b};
   endfunction
endpackage

// file: design/oag_top.sv
`timescale 1ns/10ps
`default_nettype none
module oag_top (
   input wire logic clock_i,                      // 100 MHz clock
   input wire logic rst_n_i,                      // Synchronous reset, active low
   input wire logic start_i,                      // Request, taken when idle
   input wire logic [3:0] mode_i,                 // Addressing mode
   input wire logic [7:0] opcode_i,               // Opcode byte
   input wire logic [15:0] pc_i,                  // Address of byte after opcode
   input wire logic index_sel_i,                  // 0 first, 1 second index base
   input wire logic [1:0] bit_target_i,           // Bit mode target kind
   input wire logic wide_i,                       // Indirect access is 16-bit
   input wire logic write_i,                      // Indirect access is a store
   input wire logic ext_jump_i,                   // Extended address is a jump
   input wire logic [15:0] data_i,                // Store or push data
   input wire logic [15:0] first_index_base_i,    // First index base
   input wire logic [15:0] second_index_base_i,   // Second index base
   input wire logic [15:0] pointer_pair_i,        // Pair used as indirect pointer
   input wire logic [15:0] stack_top_pointer_i,   // Current stack pointer
   input wire logic [7:0] mem_rdata_i,            // Read data, valid while mem_rd_o
   output logic busy_o,                           // Request in progress
   output logic done_o,                           // Result valid pulse
   output logic [15:0] operand_o,                 // Operand value
   output logic [15:0] eff_addr_o,                // Effective address
   output logic [15:0] next_pc_o,                 // New program counter
   output logic jump_o,                           // next_pc_o is a jump target
   output logic [2:0] src_sel_o,                  // Source register code
   output logic [2:0] dst_sel_o,                  // Destination register code
   output logic [2:0] bit_sel_o,                  // Selected bit position
   output logic [15:0] new_sp_o,                  // Updated stack pointer
   output logic sp_we_o,                          // Write new_sp_o pulse
   output logic pair_load_o,                      // Load operand_o into pair pulse
   output logic [15:0] mem_addr_o,                // Memory address
   output logic mem_rd_o,                         // Memory read strobe
   output logic mem_wr_o,                         // Memory write strobe
   output logic [7:0] mem_wdata_o                 // Memory write data
);
   typedef enum logic [2:0] {S_IDLE, S_RD1, S_RD2, S_WR1, S_WR2} oag_state_t;

   typedef struct packed {
      oag_state_t st;
      oag_pkg::oag_mode_t mode;
      logic [15:0] pc;
      logic [15:0] ptr;
      logic [15:0] wdata;
      logic [7:0] lo;
      logic want2;
      logic write;
      logic ext_jump;
      logic busy;
      logic done;
      logic [15:0] operand;
      logic [15:0] eff_addr;
      logic [15:0] next_pc;
      logic jump;
      logic [2:0] src_sel;
      logic [2:0] dst_sel;
      logic [2:0] bit_sel;
      logic [15:0] new_sp;
      logic sp_we;
      logic pair_load;
      logic [15:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
   } oag_regs_t;

   oag_regs_t r;
   oag_regs_t next_r;
   logic [15:0] add_base;
   logic [15:0] disp_sum;

   assign add_base = (r.mode == oag_pkg::OAG_REL) ? r.pc + oag_pkg::STEP_ONE : r.ptr;

   oag_disp_add u_disp (
      .base_i(add_base),
      .disp_i(mem_rdata_i),
      .sum_o(disp_sum)
   );

   always_comb begin
      logic fin;
      logic [7:0] b0;
      logic [7:0] b1;
      oag_pkg::oag_mode_t m;
      fin = 1'b0;
      b0 = oag_pkg::ZERO_BYTE;
      b1 = oag_pkg::ZERO_BYTE;
      m = oag_pkg::oag_mode_t'(mode_i);
      next_r = r;
      next_r.done = 1'b0;
      next_r.jump = 1'b0;
      next_r.sp_we = 1'b0;
      next_r.pair_load = 1'b0;
      next_r.mem_rd = 1'b0;
      next_r.mem_wr = 1'b0;
      unique case (r.st)
         S_IDLE: begin
            if (start_i) begin
               next_r.mode = m;
               next_r.pc = pc_i;
               next_r.wdata = data_i;
               next_r.write = write_i;
               next_r.ext_jump = ext_jump_i;
               next_r.want2 = 1'b0;
               next_r.ptr = pointer_pair_i;
               next_r.busy = 1'b1;
               next_r.mem_addr = pc_i;
               next_r.mem_rd = 1'b1;
               next_r.st = S_RD1;
               case (m)
                  oag_pkg::OAG_IMM8, oag_pkg::OAG_REL: begin
                  end
                  oag_pkg::OAG_IMM16, oag_pkg::OAG_EXT: begin
                     next_r.want2 = 1'b1;
                  end
                  oag_pkg::OAG_IDX: begin
                     next_r.ptr = index_sel_i ? second_index_base_i : first_index_base_i;
                  end
                  oag_pkg::OAG_BIT: begin
                     next_r.bit_sel = opcode_i[oag_pkg::OPC_HI_MSB:oag_pkg::OPC_HI_LSB];
                     next_r.ptr = index_sel_i ? second_index_base_i : first_index_base_i;
                     case (oag_pkg::oag_bit_tgt_t'(bit_target_i))
                        oag_pkg::OAG_TGT_IDX: begin
                        end
                        oag_pkg::OAG_TGT_IND: begin
                           next_r.eff_addr = pointer_pair_i;
                           fin = 1'b1;
                        end
                        default: begin
                           next_r.src_sel = opcode_i[oag_pkg::OPC_LO_MSB:oag_pkg::OPC_LO_LSB];
                           next_r.dst_sel = opcode_i[oag_pkg::OPC_LO_MSB:oag_pkg::OPC_LO_LSB];
                           fin = 1'b1;
                        end
                     endcase
                  end
                  oag_pkg::OAG_REG: begin
                     next_r.src_sel = opcode_i[oag_pkg::OPC_LO_MSB:oag_pkg::OPC_LO_LSB];
                     next_r.dst_sel = opcode_i[oag_pkg::OPC_HI_MSB:oag_pkg::OPC_HI_LSB];
                     fin = 1'b1;
                  end
                  oag_pkg::OAG_IMPL: begin
                     next_r.src_sel = opcode_i[oag_pkg::OPC_LO_MSB:oag_pkg::OPC_LO_LSB];
                     next_r.dst_sel = oag_pkg::ACC_CODE;
                     fin = 1'b1;
                  end
                  oag_pkg::OAG_RST: begin
                     next_r.next_pc = {oag_pkg::RST_UPPER, opcode_i[oag_pkg::OPC_HI_MSB:oag_pkg::OPC_HI_LSB],
                                       oag_pkg::RST_LOWER};
                     next_r.jump = 1'b1;
                     fin = 1'b1;
                  end
                  oag_pkg::OAG_REGIND: begin
                     next_r.eff_addr = pointer_pair_i;
                     next_r.mem_addr = pointer_pair_i;
                     next_r.want2 = wide_i;
                     if (write_i) begin
                        next_r.mem_rd = 1'b0;
                        next_r.mem_wr = 1'b1;
                        next_r.mem_wdata = data_i[7:0];
                        next_r.st = S_WR1;
                     end
                  end
                  oag_pkg::OAG_PUSH: begin
                     next_r.ptr = stack_top_pointer_i;
                     next_r.want2 = 1'b1;
                     next_r.mem_rd = 1'b0;
                     next_r.mem_wr = 1'b1;
                     next_r.mem_addr = stack_top_pointer_i - oag_pkg::STEP_ONE;
                     next_r.mem_wdata = data_i[15:8];
                     next_r.st = S_WR1;
                  end
                  oag_pkg::OAG_POP: begin
                     next_r.ptr = stack_top_pointer_i;
                     next_r.want2 = 1'b1;
                     next_r.mem_addr = stack_top_pointer_i;
                  end
                  default: begin
                     // Unknown mode code: answer at once with no memory access
                     fin = 1'b1;
                  end
               endcase
               if (fin) begin
                  next_r.mem_rd = 1'b0;
                  next_r.mem_wr = 1'b0;
                  next_r.st = S_IDLE;
                  next_r.busy = 1'b0;
                  next_r.done = 1'b1;
                  fin = 1'b0;
               end
            end
         end
         S_RD1: begin
            if (r.want2) begin
               next_r.lo = mem_rdata_i;
               next_r.mem_addr = r.mem_addr + oag_pkg::STEP_ONE;
               next_r.mem_rd = 1'b1;
               next_r.st = S_RD2;
            end else begin
               b0 = mem_rdata_i;
               fin = 1'b1;
            end
         end
         S_RD2: begin
            b0 = r.lo;
            b1 = mem_rdata_i;
            fin = 1'b1;
         end
         S_WR1: begin
            if (r.want2) begin
               next_r.mem_wr = 1'b1;
               if (r.mode == oag_pkg::OAG_PUSH) begin
                  next_r.mem_addr = r.ptr - oag_pkg::STEP_TWO;
                  next_r.mem_wdata = r.wdata[7:0];
               end else begin
                  next_r.mem_addr = r.mem_addr + oag_pkg::STEP_ONE;
                  next_r.mem_wdata = r.wdata[15:8];
               end
               next_r.st = S_WR2;
            end else begin
               fin = 1'b1;
            end
         end
         S_WR2: begin
            fin = 1'b1;
         end
      endcase
      if (fin) begin
         next_r.st = S_IDLE;
         next_r.busy = 1'b0;
         next_r.done = 1'b1;
         case (r.mode)
            oag_pkg::OAG_IMM8: begin
               next_r.operand = {oag_pkg::ZERO_BYTE, b0};
               next_r.next_pc = r.pc + oag_pkg::STEP_ONE;
            end
            oag_pkg::OAG_IMM16: begin
               next_r.operand = {b1, b0};
               next_r.next_pc = r.pc + oag_pkg::STEP_TWO;
            end
            oag_pkg::OAG_EXT: begin
               next_r.eff_addr = {b1, b0};
               next_r.jump = r.ext_jump;
               next_r.next_pc = r.ext_jump ? {b1, b0} : r.pc + oag_pkg::STEP_TWO;
            end
            oag_pkg::OAG_REL: begin
               next_r.next_pc = disp_sum;
               next_r.jump = 1'b1;
            end
            oag_pkg::OAG_IDX, oag_pkg::OAG_BIT: begin
               next_r.eff_addr = disp_sum;
               next_r.next_pc = r.pc + oag_pkg::STEP_ONE;
            end
            oag_pkg::OAG_REGIND: begin
               next_r.operand = r.write ? r.wdata : (r.want2 ? {b1, b0} : {oag_pkg::ZERO_BYTE, b0});
            end
            oag_pkg::OAG_POP: begin
               next_r.operand = {b1, b0};
               next_r.pair_load = 1'b1;
               next_r.new_sp = r.ptr + oag_pkg::STEP_TWO;
               next_r.sp_we = 1'b1;
            end
            oag_pkg::OAG_PUSH: begin
               next_r.new_sp = r.ptr - oag_pkg::STEP_TWO;
               next_r.sp_we = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busy_o = r.busy;
   assign done_o = r.done;
   assign operand_o = r.operand;
   assign eff_addr_o = r.eff_addr;
   assign next_pc_o = r.next_pc;
   assign jump_o = r.jump;
   assign src_sel_o = r.src_sel;
   assign dst_sel_o = r.dst_sel;
   assign bit_sel_o = r.bit_sel;
   assign new_sp_o = r.new_sp;
   assign sp_we_o = r.sp_we;
   assign pair_load_o = r.pair_load;
   assign mem_addr_o = r.mem_addr;
   assign mem_rd_o = r.mem_rd;
   assign mem_wr_o = r.mem_wr;
   assign mem_wdata_o = r.mem_wdata;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   logic take;
   assign take = start_i && (r.st == S_IDLE);

   chk_imm8_value: assert property (
      take && mode_i == oag_pkg::OAG_IMM8 |=> mem_rd_o && mem_addr_o == $past(pc_i)
      ##1 done_o && operand_o == {oag_pkg::ZERO_BYTE, $past(mem_rdata_i)})
      else $error("immediate byte not delivered as operand");
   chk_imm16_order: assert property (
      take && mode_i == oag_pkg::OAG_IMM16 |=> mem_rd_o && mem_addr_o == $past(pc_i)
      ##1 mem_rd_o && mem_addr_o == $past(pc_i, 2) + oag_pkg::STEP_ONE
      ##1 done_o && operand_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)})
      else $error("immediate word order wrong");
   chk_rst_target: assert property (
      take && mode_i == oag_pkg::OAG_RST |=> done_o && jump_o && !mem_rd_o
      && next_pc_o == {oag_pkg::RST_UPPER, $past(opcode_i[5:3]), oag_pkg::RST_LOWER})
      else $error("restart target wrong");
   chk_rel_target: assert property (
      r.st == S_RD1 && r.mode == oag_pkg::OAG_REL |=> done_o && jump_o
      && next_pc_o == $past(r.pc) + oag_pkg::STEP_ONE + oag_pkg::sext8($past(mem_rdata_i)))
      else $error("relative target wrong");
   chk_ext_jump: assert property (
      take && mode_i == oag_pkg::OAG_EXT && ext_jump_i |=> ##2 done_o && jump_o
      && next_pc_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)})
      else $error("extended jump target wrong");
   chk_idx_sum: assert property (
      r.st == S_RD1 && r.mode == oag_pkg::OAG_IDX |=> done_o
      && eff_addr_o == $past(r.ptr) + oag_pkg::sext8($past(mem_rdata_i)))
      else $error("indexed address wrong");
   chk_reg_fields: assert property (
      take && mode_i == oag_pkg::OAG_REG |=> done_o && src_sel_o == $past(opcode_i[2:0])
      && dst_sel_o == $past(opcode_i[5:3]))
      else $error("register fields wrong");
   chk_impl_acc: assert property (
      take && mode_i == oag_pkg::OAG_IMPL |=> done_o && dst_sel_o == oag_pkg::ACC_CODE)
      else $error("implied destination not accumulator");
   chk_ind_wide: assert property (
      take && mode_i == oag_pkg::OAG_REGIND && wide_i && !write_i |=> mem_rd_o
      && mem_addr_o == $past(pointer_pair_i) ##1 mem_rd_o && mem_addr_o == $past(pointer_pair_i, 2) + oag_pkg::STEP_ONE)
      else $error("indirect word addresses wrong");
   chk_bit_field: assert property (
      take && mode_i == oag_pkg::OAG_BIT |=> bit_sel_o == $past(opcode_i[5:3]))
      else $error("bit position wrong");
   chk_push_seq: assert property (
      take && mode_i == oag_pkg::OAG_PUSH |=> mem_wr_o && mem_addr_o == $past(stack_top_pointer_i) - oag_pkg::STEP_ONE
      && mem_wdata_o == $past(data_i[15:8])
      ##1 mem_wr_o && mem_addr_o == $past(stack_top_pointer_i, 2) - oag_pkg::STEP_TWO && mem_wdata_o == $past(data_i[7:0], 2)
      ##1 done_o && sp_we_o && new_sp_o == $past(stack_top_pointer_i, 3) - oag_pkg::STEP_TWO)
      else $error("push sequence wrong");
   chk_pop_seq: assert property (
      take && mode_i == oag_pkg::OAG_POP |=> mem_rd_o && mem_addr_o == $past(stack_top_pointer_i)
      ##1 mem_rd_o && mem_addr_o == $past(stack_top_pointer_i, 2) + oag_pkg::STEP_ONE
      ##1 done_o && sp_we_o && pair_load_o && new_sp_o == $past(stack_top_pointer_i, 3) + oag_pkg::STEP_TWO
      && operand_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)})
      else $error("pop sequence wrong");

   cov_push: cover property (take && mode_i == oag_pkg::OAG_PUSH ##3 done_o);
   cov_pop: cover property (take && mode_i == oag_pkg::OAG_POP ##3 done_o);
   cov_rel_back: cover property (r.st == S_RD1 && r.mode == oag_pkg::OAG_REL && mem_rdata_i[7]);
   cov_ind_store: cover property (take && mode_i == oag_pkg::OAG_REGIND && write_i && wide_i ##3 done_o);
endmodule
`default_nettype wire

// file: testbench/oag_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module oag_mem_model (
   input wire logic clock_i,        // System clock
   input wire logic [15:0] addr_i,  // Byte address
   input wire logic rd_i,           // Read strobe
   input wire logic wr_i,           // Write strobe
   input wire logic [7:0] wdata_i,  // Write data
   output logic [7:0] rdata_o       // Read data, same cycle as rd_i
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_rd = 8'h00;
   // Outside a read the bus shows the inverse of the last byte, so a stale sample cannot pass
   assign rdata_o = rd_i ? mem[addr_i] : ~last_rd;
   always @(posedge clock_i) begin
      if (rd_i) begin
         last_rd <= mem[addr_i];
      end
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct {logic [3:0] m; logic [6:0] ck; logic [15:0] op, ea, npc, nsp; logic jmp; logic [2:0] src, dst, bs;} oag_exp_t;
   logic clock_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, index_sel_i = 1'b0, wide_i = 1'b0, write_i = 1'b0;
   logic ext_jump_i = 1'b0, busy_o, done_o, jump_o, sp_we_o, pair_load_o, mem_rd_o, mem_wr_o;
   logic [3:0] mode_i = 4'h0;
   logic [1:0] bit_target_i = 2'h0;
   logic [7:0] opcode_i = 8'h00, mem_rdata_i, mem_wdata_o, b, d;
   logic [15:0] pc_i = 16'h0000, data_i = 16'h0000, first_index_base_i = 16'h0000, second_index_base_i = 16'h0000;
   logic [15:0] pointer_pair_i = 16'h0000, stack_top_pointer_i = 16'h0000, operand_o, eff_addr_o, next_pc_o;
   logic [15:0] new_sp_o, mem_addr_o, pc, ixa, ixb, ptr, sp, dat, w;
   logic [2:0] src_sel_o, dst_sel_o, bit_sel_o;
   logic isel, wd, wr, ej;
   logic [1:0] bt;
   int failures = 0, samples_checked = 0;
   oag_exp_t exp_q[$];
   oag_exp_t me;
   always #5 clock_i = ~clock_i;
   oag_top u_oag_top (.clock_i, .rst_n_i, .start_i, .mode_i, .opcode_i, .pc_i, .index_sel_i, .bit_target_i,
      .wide_i, .write_i, .ext_jump_i, .data_i, .first_index_base_i, .second_index_base_i, .pointer_pair_i,
      .stack_top_pointer_i, .mem_rdata_i, .busy_o, .done_o, .operand_o, .eff_addr_o, .next_pc_o, .jump_o,
      .src_sel_o, .dst_sel_o, .bit_sel_o, .new_sp_o, .sp_we_o, .pair_load_o, .mem_addr_o, .mem_rd_o,
      .mem_wr_o, .mem_wdata_o);
   oag_mem_model u_oag_mem_model (.clock_i(clock_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic [15:0] sx(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction
   function automatic oag_exp_t x(logic [6:0] ck, logic [15:0] op, ea, npc, nsp, logic jmp = 1'b0,
      logic [2:0] src = 3'h0, dst = 3'h0, bs = 3'h0);
      return '{4'h0, ck, op, ea, npc, nsp, jmp, src, dst, bs};
   endfunction
   task automatic issue(input logic [3:0] m, input logic [7:0] op, input oag_exp_t e);
      int n;
      e.m = m;
      @(posedge clock_i);
      mode_i <= m;
      opcode_i <= op;
      pc_i <= pc;
      index_sel_i <= isel;
      bit_target_i <= bt;
      wide_i <= wd;
      write_i <= wr;
      ext_jump_i <= ej;
      data_i <= dat;
      first_index_base_i <= ixa;
      second_index_base_i <= ixb;
      pointer_pair_i <= ptr;
      stack_top_pointer_i <= sp;
      start_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock_i);
      start_i <= 1'b0;
      #1;
      n = 0;
      while (done_o !== 1'b1 && n < 8) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (n == 8) begin
         failures++;
         $display("[ERR] %0t no completion", $time);
      end
   endtask
   // Result monitor: every completion consumes the oldest expectation
   always @(posedge clock_i) begin
      if (rst_n_i === 1'b1 && done_o === 1'b1) begin
         me = exp_q.pop_front();
         if (me.ck[0]) check(operand_o, me.op);
         if (me.ck[1]) check(eff_addr_o, me.ea);
         if (me.ck[2]) check(next_pc_o, me.npc);
         if (me.ck[4]) check({10'h000, src_sel_o, dst_sel_o}, {10'h000, me.src, me.dst});
         if (me.ck[5]) check({13'h0000, bit_sel_o}, {13'h0000, me.bs});
         if (me.ck[6]) check(new_sp_o, me.nsp);
         check({14'h0000, jump_o, sp_we_o}, {14'h0000, me.jmp, me.ck[6]});
         check({15'h0000, pair_load_o}, {15'h0000, me.m == oag_pkg::OAG_POP});
         check({15'h0000, busy_o}, 16'h0000);
      end
   end
   initial begin
      #50000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      void'($urandom(77));
      {isel, wd, wr, ej, bt, dat, ptr, sp, ixa, ixb, pc} = '0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         pc = {4'h1, 12'($urandom)};
         ixa = {4'h2, 12'($urandom)};
         ixb = {4'h3, 12'($urandom)};
         ptr = {4'h4, 12'($urandom)};
         sp = {4'h8, 12'($urandom)};
         w = 16'($urandom);
         dat = 16'($urandom);
         d = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($urandom);
         isel = k[0];
         u_oag_mem_model.mem[pc] = w[7:0];
         u_oag_mem_model.mem[pc + 16'h0001] = w[15:8];
         issue(oag_pkg::OAG_IMM8, 8'h3e, x(7'h05, {8'h00, w[7:0]}, 16'h0000, pc + 16'h0001, 16'h0000));
         issue(oag_pkg::OAG_IMM16, 8'h21, x(7'h05, w, 16'h0000, pc + 16'h0002, 16'h0000));
         issue(oag_pkg::OAG_EXT, 8'h3a, x(7'h06, 16'h0000, w, pc + 16'h0002, 16'h0000));
         ej = 1'b1;
         issue(oag_pkg::OAG_EXT, 8'hc3, x(7'h04, 16'h0000, 16'h0000, w, 16'h0000, 1'b1));
         ej = 1'b0;
         u_oag_mem_model.mem[pc] = d;
         issue(oag_pkg::OAG_REL, 8'h18, x(7'h04, 16'h0000, 16'h0000, pc + 16'h0001 + sx(d), 16'h0000, 1'b1));
         issue(oag_pkg::OAG_IDX, 8'h7e, x(7'h06, 16'h0000, (isel ? ixb : ixa) + sx(d), pc + 16'h0001, 16'h0000));
         wd = 1'b0;
         u_oag_mem_model.mem[ptr] = w[15:8];
         u_oag_mem_model.mem[ptr + 16'h0001] = w[7:0];
         issue(oag_pkg::OAG_REGIND, 8'h7e, x(7'h03, {8'h00, w[15:8]}, ptr, 16'h0000, 16'h0000));
         wd = 1'b1;
         issue(oag_pkg::OAG_REGIND, 8'h7e, x(7'h03, {w[7:0], w[15:8]}, ptr, 16'h0000, 16'h0000));
         wr = 1'b1;
         issue(oag_pkg::OAG_REGIND, 8'h77, x(7'h03, dat, ptr, 16'h0000, 16'h0000));
         check({u_oag_mem_model.mem[ptr + 16'h0001], u_oag_mem_model.mem[ptr]}, dat);
         wr = 1'b0;
         issue(oag_pkg::OAG_PUSH, 8'hc5, x(7'h40, 16'h0000, 16'h0000, 16'h0000, sp - 16'h0002));
         check({u_oag_mem_model.mem[sp - 16'h0001], u_oag_mem_model.mem[sp - 16'h0002]}, dat);
         sp = sp - 16'h0002;
         issue(oag_pkg::OAG_POP, 8'hc1, x(7'h41, dat, 16'h0000, 16'h0000, sp + 16'h0002));
         b = 8'($urandom);
         issue(oag_pkg::OAG_REG, b, x(7'h10, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, b[2:0], b[5:3]));
         issue(oag_pkg::OAG_IMPL, b, x(7'h10, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, b[2:0], 3'h7));
         // Unused mode code answers at once with no jump, stack or pair strobe
         issue(4'hc, b, x(7'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000));
      end
      isel = 1'b0;
      for (int i = 0; i < 8; i++) begin
         b = {2'b11, 3'(i), 3'h7};
         issue(oag_pkg::OAG_RST, b, x(7'h04, 16'h0000, 16'h0000, {10'h000, 3'(i), 3'h0}, 16'h0000, 1'b1));
         bt = 2'(i % 3);
         b = {2'b01, 3'(i), 3'($urandom)};
         issue(oag_pkg::OAG_BIT, b, x((bt == 2'h0) ? 7'h30 : (bt == 2'h1) ? 7'h22 : 7'h26, 16'h0000,
            (bt == 2'h1) ? ptr : ixa + sx(d), pc + 16'h0001, 16'h0000, 1'b0, b[2:0], b[2:0], 3'(i)));
      end
      repeat (2) @(posedge clock_i);
      complete_run();
   end
endmodule
`default_nettype wire
